// ### hdl/dbt_defs.vh
`ifndef DBT_DEFS_VH
`define DBT_DEFS_VH

// ==========================================================
// register indices (byte address = index * 4)
`define DBT_IDX_CONTROL        16'hfe18
`define DBT_IDX_PRESCALE       16'hfe19
`define DBT_IDX_LOW_COUNT      16'hfe1a
`define DBT_IDX_HIGH_COUNT     16'hfe1b
`define DBT_IDX_LOW_MATCH      16'hfe1c
`define DBT_IDX_HIGH_MATCH     16'hfe1d
`define DBT_IDX_LSB            2
`define DBT_IDX_MSB            17
`define DBT_IDX_W              16

// ==========================================================
// timer_control fields
`define DBT_CTL_HIGH_RUN       7
`define DBT_CTL_LOW_RUN        6
`define DBT_CTL_CASCADE        5
`define DBT_CTL_PWM            4
`define DBT_CTL_HIGH_FLAG      3
`define DBT_CTL_HIGH_IE        2
`define DBT_CTL_LOW_FLAG       1
`define DBT_CTL_LOW_IE         0

// ==========================================================
// timer_prescale_config fields
`define DBT_PRE_HIGH_EN        7
`define DBT_PRE_HIGH_CODE      6:4
`define DBT_PRE_LOW_EN         3
`define DBT_PRE_LOW_CODE       2:0

// ==========================================================
// reset values and constants
`define DBT_RST_BYTE           8'h00
`define DBT_BYTE_ALL_ONES      8'hff
`define DBT_DIV_ONE            9'h001
`define DBT_DIV_BASE           9'h002

// ==========================================================
// modes {cascade_select, pwm_select}
`define DBT_MODE_SPLIT_TIMER   2'h0
`define DBT_MODE_DUAL_PWM      2'h1
`define DBT_MODE_CASCADE       2'h2
`define DBT_MODE_CASCADE_PWM   2'h3

// ==========================================================
// axi4-lite responses
`define DBT_RESP_OKAY          2'h0
`define DBT_RESP_SLVERR        2'h2

`endif

// ### hdl/dbt_byte_timer.v
`timescale 1ns/10ps
`include "dbt_defs.vh"

module dbt_byte_timer (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       run,
  input  wire       tick,
  input  wire       presc_en,
  input  wire [2:0] presc_code,
  input  wire [7:0] match_data,
  input  wire       clear_on_match,
  input  wire       pwm_mode,
  output reg  [7:0] count_reg,
  output wire       match_pulse,
  output wire       zero_pulse,
  output wire       overflow_pulse,
  output reg        wave_reg
);

  // ==========================================================
  // prescaler
  reg  [7:0] presc_reg;
  reg  [7:0] buf_reg;
  wire [8:0] div_count;
  wire       presc_done;
  wire       count_clear;

  function [8:0] dbt_div_count;
    input       en;
    input [2:0] code;
    begin
      if (en)
        dbt_div_count = `DBT_DIV_BASE << code;
      else
        dbt_div_count = `DBT_DIV_ONE;
    end
  endfunction

  assign div_count      = dbt_div_count(presc_en, presc_code);
  assign presc_done     = run & tick & ({1'b0, presc_reg} == div_count - `DBT_DIV_ONE);
  assign match_pulse    = presc_done & (count_reg == buf_reg);
  assign count_clear    = match_pulse & clear_on_match;
  assign overflow_pulse = presc_done & (count_reg == `DBT_BYTE_ALL_ONES) & ~count_clear;
  assign zero_pulse     = count_clear | overflow_pulse;

  always @(posedge aclk)
  begin
    if (!aresetn)
      presc_reg <= `DBT_RST_BYTE;
    else if (!run || count_clear || presc_done)
      presc_reg <= `DBT_RST_BYTE;
    else if (tick)
      presc_reg <= presc_reg + 8'h01;
  end

  // ==========================================================
  // counter and match buffer
  always @(posedge aclk)
  begin
    if (!aresetn)
      count_reg <= `DBT_RST_BYTE;
    else if (!run || count_clear)
      count_reg <= `DBT_RST_BYTE;
    else if (presc_done)
      count_reg <= count_reg + 8'h01;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      buf_reg <= `DBT_RST_BYTE;
    else if (!run || zero_pulse)
      buf_reg <= match_data;
  end

  // ==========================================================
  // wave output
  always @(posedge aclk)
  begin
    if (!aresetn)
      wave_reg <= 1'b1;
    else if (!run)
      wave_reg <= 1'b1;
    else if (match_data == `DBT_BYTE_ALL_ONES)
      wave_reg <= 1'b0;
    else if (pwm_mode)
    begin
      if (match_pulse)
        wave_reg <= 1'b1;
      else if (overflow_pulse)
        wave_reg <= 1'b0;
    end
    else if (match_pulse)
      wave_reg <= ~wave_reg;
  end

endmodule

// ### hdl/dbt_timer_top.v
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`include "dbt_defs.vh"

module dbt_timer_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        event_input_pin,
  input  wire        event_select,
  output wire        low_wave_out,
  output wire        high_wave_out,
  output reg         irq_req
);

  // ==========================================================
  // register decode
  function [2:0] dbt_decode;
    input [31:0] addr;
    reg   [`DBT_IDX_W-1:0] idx;
    begin
      idx = addr[`DBT_IDX_MSB:`DBT_IDX_LSB];
      if (addr[31:`DBT_IDX_MSB+1] != 14'h0000)
        dbt_decode = 3'h7;
      else if (idx == `DBT_IDX_CONTROL)
        dbt_decode = 3'h0;
      else if (idx == `DBT_IDX_PRESCALE)
        dbt_decode = 3'h1;
      else if (idx == `DBT_IDX_LOW_COUNT)
        dbt_decode = 3'h2;
      else if (idx == `DBT_IDX_HIGH_COUNT)
        dbt_decode = 3'h3;
      else if (idx == `DBT_IDX_LOW_MATCH)
        dbt_decode = 3'h4;
      else if (idx == `DBT_IDX_HIGH_MATCH)
        dbt_decode = 3'h5;
      else
        dbt_decode = 3'h7;
    end
  endfunction

  localparam [2:0] SEL_CONTROL  = 3'h0;
  localparam [2:0] SEL_PRESCALE = 3'h1;
  localparam [2:0] SEL_LOW_CNT  = 3'h2;
  localparam [2:0] SEL_HIGH_CNT = 3'h3;
  localparam [2:0] SEL_LOW_MAT  = 3'h4;
  localparam [2:0] SEL_HIGH_MAT = 3'h5;
  localparam [2:0] SEL_NONE     = 3'h7;

  // ==========================================================
  // registers
  reg  [7:0]  control_reg;
  reg  [7:0]  prescale_reg;
  reg  [7:0]  low_match_data_reg;
  reg  [7:0]  high_match_data_reg;
  reg  [7:0]  control_next;
  reg         aw_held_reg;
  reg  [31:0] aw_addr_reg;
  reg         w_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  wire        low_run;
  wire        high_run;
  wire        cascade_select;
  wire        pwm_select;
  wire [1:0]  mode;
  wire [7:0]  low_counter;
  wire [7:0]  high_counter;
  wire        low_match;
  wire        low_zero;
  wire        low_overflow;
  wire        high_match;
  wire        high_zero;
  wire        high_overflow;
  wire        do_write;
  wire [2:0]  wr_sel;
  wire [2:0]  rd_sel;
  wire        wr_lane0;
  reg         div2_reg;
  reg         event_prev_reg;
  wire        event_edge;
  wire        div2_tick;
  reg         low_tick;
  reg         high_tick;
  reg         low_clear_on_match;
  reg         high_clear_on_match;
  reg         high_pwm_mode;
  assign low_run        = control_reg[`DBT_CTL_LOW_RUN];
  assign high_run       = control_reg[`DBT_CTL_HIGH_RUN];
  assign cascade_select = control_reg[`DBT_CTL_CASCADE];
  assign pwm_select     = control_reg[`DBT_CTL_PWM];
  assign mode           = {cascade_select, pwm_select};

  // ==========================================================
  // clock sources: two-cycle enable and event edges
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div2_reg       <= 1'b0;
      event_prev_reg <= 1'b0;
    end
    else
    begin
      div2_reg       <= ~div2_reg;
      event_prev_reg <= event_input_pin;
    end
  end

  // a rising edge of the pin is one event; the pin is taken as already synchronous
  assign event_edge = event_input_pin & ~event_prev_reg;
  assign div2_tick  = div2_reg;

  // ==========================================================
  // mode steering
  always @*
  begin
    low_tick            = 1'b0;
    high_tick           = 1'b0;
    low_clear_on_match  = 1'b1;
    high_clear_on_match = 1'b1;
    high_pwm_mode       = 1'b0;
    case (mode)
      `DBT_MODE_SPLIT_TIMER:
      begin
        low_tick  = event_select ? event_edge : div2_tick;
        high_tick = div2_tick;
      end
      `DBT_MODE_DUAL_PWM:
      begin
        // an event selection here is ignored; software must avoid it
        low_tick            = 1'b1;
        high_tick           = 1'b1;
        low_clear_on_match  = 1'b0;
        high_clear_on_match = 1'b0;
        high_pwm_mode       = 1'b1;
      end
      `DBT_MODE_CASCADE:
      begin
        low_tick  = event_select ? event_edge : div2_tick;
        high_tick = low_match;
      end
      `DBT_MODE_CASCADE_PWM:
      begin
        low_tick           = 1'b1;
        high_tick          = low_overflow;
        low_clear_on_match = 1'b0;
      end
      default:
        low_tick = 1'b0;
    endcase
  end

  // ==========================================================
  // byte counters
  dbt_byte_timer u_low (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .run            (low_run),
    .tick           (low_tick),
    .presc_en       (prescale_reg[`DBT_PRE_LOW_EN]),
    .presc_code     (prescale_reg[`DBT_PRE_LOW_CODE]),
    .match_data     (low_match_data_reg),
    .clear_on_match (low_clear_on_match),
    .pwm_mode       (pwm_select),
    .count_reg      (low_counter),
    .match_pulse    (low_match),
    .zero_pulse     (low_zero),
    .overflow_pulse (low_overflow),
    .wave_reg       (low_wave_out)
  );

  // high wave toggles whenever cascaded, even in mode 3
  dbt_byte_timer u_high (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .run            (high_run),
    .tick           (high_tick),
    .presc_en       (prescale_reg[`DBT_PRE_HIGH_EN]),
    .presc_code     (prescale_reg[`DBT_PRE_HIGH_CODE]),
    .match_data     (high_match_data_reg),
    .clear_on_match (high_clear_on_match),
    .pwm_mode       (high_pwm_mode),
    .count_reg      (high_counter),
    .match_pulse    (high_match),
    .zero_pulse     (high_zero),
    .overflow_pulse (high_overflow),
    .wave_reg       (high_wave_out)
  );

  // ==========================================================
  // axi4-lite write channel
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_sel   = dbt_decode(aw_addr_reg);
  assign wr_lane0 = w_strb_reg[0];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= 32'h0000_0000;
      w_held_reg    <= 1'b0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DBT_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == SEL_NONE) ? `DBT_RESP_SLVERR : `DBT_RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // control register: flags set by hardware win over a software clear
  always @*
  begin
    control_next = control_reg;
    if (do_write && wr_lane0 && wr_sel == SEL_CONTROL)
    begin
      control_next = w_data_reg[7:0];
      // writing 1 to a flag leaves it as it is; only 0 clears it
      control_next[`DBT_CTL_HIGH_FLAG] = control_reg[`DBT_CTL_HIGH_FLAG] & w_data_reg[`DBT_CTL_HIGH_FLAG];
      control_next[`DBT_CTL_LOW_FLAG]  = control_reg[`DBT_CTL_LOW_FLAG] & w_data_reg[`DBT_CTL_LOW_FLAG];
    end
    if (low_zero)
      control_next[`DBT_CTL_LOW_FLAG] = 1'b1;
    if (high_zero)
      control_next[`DBT_CTL_HIGH_FLAG] = 1'b1;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_reg         <= `DBT_RST_BYTE;
      prescale_reg        <= `DBT_RST_BYTE;
      low_match_data_reg  <= `DBT_RST_BYTE;
      high_match_data_reg <= `DBT_RST_BYTE;
    end
    else
    begin
      control_reg <= control_next;
      if (do_write && wr_lane0 && wr_sel == SEL_PRESCALE)
        prescale_reg <= w_data_reg[7:0];
      if (do_write && wr_lane0 && wr_sel == SEL_LOW_MAT)
        low_match_data_reg <= w_data_reg[7:0];
      if (do_write && wr_lane0 && wr_sel == SEL_HIGH_MAT)
        high_match_data_reg <= w_data_reg[7:0];
    end
  end

  // ==========================================================
  // interrupt request
  always @(posedge aclk)
  begin
    if (!aresetn)
      irq_req <= 1'b0;
    else
      irq_req <= (control_next[`DBT_CTL_LOW_FLAG] & control_next[`DBT_CTL_LOW_IE]) |
                 (control_next[`DBT_CTL_HIGH_FLAG] & control_next[`DBT_CTL_HIGH_IE]);
  end

  // ==========================================================
  // axi4-lite read channel
  assign rd_sel = dbt_decode(s_axi_araddr);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DBT_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `DBT_RESP_OKAY;
        case (rd_sel)
          SEL_CONTROL:  s_axi_rdata <= {24'h000000, control_reg};
          SEL_PRESCALE: s_axi_rdata <= {24'h000000, prescale_reg};
          SEL_LOW_CNT:  s_axi_rdata <= {24'h000000, low_counter};
          SEL_HIGH_CNT: s_axi_rdata <= {24'h000000, high_counter};
          SEL_LOW_MAT:  s_axi_rdata <= {24'h000000, low_match_data_reg};
          SEL_HIGH_MAT: s_axi_rdata <= {24'h000000, high_match_data_reg};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DBT_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ### dv/dbt_timer_sva.sv
`timescale 1ns/10ps
`include "dbt_defs.vh"

// ==========================================
// bus and output relations at the top ports
module dbt_timer_sva (
  input logic        aclk,
  input logic        aresetn,
  input logic [31:0] s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_awready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        low_wave_out,
  input logic        high_wave_out,
  input logic        irq_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire [15:0] ridx  = s_axi_araddr[17:2];
  // high or misaligned addresses are left alone: the decode ignores bits 1:0 and refuses any high address bits
  wire        plain = s_axi_araddr[31:18] == 14'h0 && s_axi_araddr[1:0] == 2'h0;
  wire        hit   = plain && ridx >= `DBT_IDX_CONTROL && ridx <= `DBT_IDX_HIGH_MATCH;
  wire        take  = s_axi_arvalid && s_axi_arready;

  reset_state_a: assert property ($rose(aresetn) |-> low_wave_out && high_wave_out && !irq_req
    && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs not at rest after reset");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read response dropped");
  r_answer_a: assert property (take |=> s_axi_rvalid) else $error("read answer late");
  r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata upper bits set");
  r_okay_a: assert property (take && hit |=> s_axi_rresp == `DBT_RESP_OKAY) else $error("mapped read refused");
  r_refuse_a: assert property (take && plain && !hit |=> s_axi_rresp == `DBT_RESP_SLVERR
    && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  irq_sticky_a: assert property ($fell(irq_req) |-> s_axi_bvalid)
    else $error("irq fell without a write");

  cover property ($rose(irq_req));
  cover property ($fell(low_wave_out));
  cover property ($fell(high_wave_out));
  cover property (take && plain && !hit);
endmodule

bind dbt_timer_top dbt_timer_sva dbt_timer_sva_inst (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .low_wave_out, .high_wave_out, .irq_req);

// ### dv/dbt_event_src.sv
`timescale 1ns/10ps

// ==========================================
// external event source, pulled down when idle
module dbt_event_src (
  input  logic       aclk,
  input  logic       ev_en,
  input  logic [3:0] gap,
  output logic       event_input_pin
);
  logic [3:0] cnt_reg = 4'h0;
  initial event_input_pin = 1'b0;
  // one high cycle every gap+1 cycles; a larger gap plays a slow source
  always @(posedge aclk)
  begin
    cnt_reg <= (!ev_en || cnt_reg == gap) ? 4'h0 : cnt_reg + 4'h1;
    event_input_pin <= ev_en && cnt_reg == gap;
  end
endmodule

// ### dv/testbench.sv
`timescale 1ns/10ps
`include "dbt_defs.vh"

module testbench;
  localparam [31:0] A_CTL = {14'h0, `DBT_IDX_CONTROL, 2'h0};
  localparam [31:0] A_PRE = A_CTL + 32'h4;
  localparam [31:0] A_LC  = A_CTL + 32'h8;
  localparam [31:0] A_HC  = A_CTL + 32'hc;
  localparam [31:0] A_LM  = A_CTL + 32'h10;
  localparam [31:0] A_HM  = A_CTL + 32'h14;
  localparam [1:0]  OK    = `DBT_RESP_OKAY;
  localparam [1:0]  ERR   = `DBT_RESP_SLVERR;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        ev_sel = 0, ev_en = 0;
  logic [3:0]  gap = 4'h3, wstrb = 4'hf;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
  wire         awready, wready, bvalid, arready, rvalid, ev_pin, lw, hw, irq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          num_errors = 0, compares = 0, hold = 0;

  always #50 aclk = ~aclk;

  dbt_timer_top dbt_timer_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .event_input_pin(ev_pin), .event_select(ev_sel), .low_wave_out(lw),
    .high_wave_out(hw), .irq_req(irq));
  dbt_event_src dbt_event_src_inst (.aclk(aclk), .ev_en(ev_en), .gap(gap), .event_input_pin(ev_pin));

  // ==========================================
  // bus tasks and checks
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1;
    wvalid  <= 1;
    // a nonzero hold leaves bready low for that many edges so the response must wait
    bready  <= (hold == 0);
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 0;
      if (wvalid && wready)
        wvalid <= 0;
      if (n == hold)
        bready <= 1;
    end while (!(bvalid && bready) && n < 200);
    bready <= 0;
    chk("bvalid", 1, bvalid);
    chk("bresp", er, bresp);
  endtask

  task rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1;
    rready  <= (hold == 0);
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 0;
      if (n == hold)
        rready <= 1;
    end while (!(rvalid && rready) && n < 200);
    rready <= 0;
    chk("rvalid", 1, rvalid);
    chk("rdata", ed, rdata);
    chk("rresp", er, rresp);
  endtask

  task waitlv(input logic h, input logic lv);
    int n;
    n = 0;
    while ((h ? hw : lw) !== lv && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
  endtask

  // cycles that one wave spends at level lv, measured from a fresh entry
  task span(input string what, input logic h, input logic lv, input int exp);
    int n;
    waitlv(h, !lv);
    waitlv(h, lv);
    n = 0;
    while ((h ? hw : lw) === lv && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
    chk(what, exp, n);
  endtask

  task wrap_up;
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================
  // scenarios
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    chk("low_wave", 1, lw);
    chk("high_wave", 1, hw);
    for (int i = 0; i < 6; i++)
      rd(A_CTL + i * 4, 32'h0, OK);
    rd(A_HM + 32'h4, 32'h0, ERR);
    wr(A_CTL - 32'h4, 8'h55, ERR);
    wr(A_LC, 8'h5a, OK);
    rd(A_LC, 32'h0, OK);
    hold = 6;
    wr(A_LM, 8'h11, OK);
    rd(A_LM, 32'h11, OK);
    hold = 0;
    // byte lane 0 off: the write is answered but must leave the register alone
    wstrb <= 4'he;
    wr(A_LM, 8'h01, OK);
    wstrb <= 4'hf;
    rd(A_LM, 32'h11, OK);
    wr(A_PRE, 8'h98, OK);
    rd(A_PRE, 32'h98, OK);
    wr(A_LM, 8'h01, OK);
    wr(A_HM, 8'h02, OK);
    rd(A_HM, 32'h02, OK);
    wr(A_CTL, 8'hc0, OK);
    span("m0_low_half", 0, 1, 8);
    span("m0_high_half", 1, 0, 24);
    chk("irq_masked", 0, irq);
    rd(A_CTL, 32'hca, OK);
    wr(A_CTL, 8'hcf, OK);
    repeat (2) @(posedge aclk);
    chk("irq_on", 1, irq);
    // stop first, so that no match can set a flag in the cycle of the clear
    wr(A_CTL, 8'h0f, OK);
    chk("irq_kept", 1, irq);
    wr(A_CTL, 8'h05, OK);
    repeat (2) @(posedge aclk);
    chk("irq_cleared", 0, irq);
    chk("low_stopped", 1, lw);
    chk("high_stopped", 1, hw);
    rd(A_LC, 32'h0, OK);
    rd(A_HC, 32'h0, OK);
    rd(A_CTL, 32'h05, OK);
    wr(A_PRE, 8'h00, OK);
    wr(A_LM, 8'h03, OK);
    wr(A_HM, 8'hff, OK);
    wr(A_CTL, 8'hd0, OK);
    span("m1_low_time", 0, 0, 4);
    span("m1_high_time", 0, 1, 252);
    chk("high_all_ones", 0, hw);
    wr(A_HM, 8'h07, OK);
    span("m1_hw_low_time", 1, 0, 8);
    wr(A_CTL, 8'h00, OK);
    wr(A_LM, 8'h00, OK);
    wr(A_HM, 8'h01, OK);
    wr(A_CTL, 8'he0, OK);
    span("m2_low_half", 0, 1, 2);
    span("m2_high_half", 1, 1, 4);
    wr(A_CTL, 8'h00, OK);
    wr(A_LM, 8'h03, OK);
    wr(A_HM, 8'h00, OK);
    wr(A_CTL, 8'hf0, OK);
    span("m3_high_half", 1, 1, 256);
    span("m3_low_time", 0, 0, 4);
    wr(A_CTL, 8'h00, OK);
    wr(A_LM, 8'h01, OK);
    ev_sel <= 1;
    ev_en <= 1;
    wr(A_CTL, 8'h40, OK);
    span("ev_fast_half", 0, 1, 8);
    gap <= 4'h7;
    span("ev_slow_half", 0, 0, 16);
    wr(A_CTL, 8'h00, OK);
    ev_en <= 0;
    ev_sel <= 0;
    wrap_up;
  end

  initial
  begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    wrap_up;
  end
endmodule
